// File: mrf_regs.vh
// Constants for the magnetometer reading framer: register offsets, field positions,
// reset values, frame bytes and timing counts.
// Assumes inclusion by bare name from the design files of the framer only.
`ifndef MRF_REGS_VH
`define MRF_REGS_VH

// ====================================================================
// Register map
`define MRF_ADDR_W        4
`define MRF_OFS_CTRL      4'h0
`define MRF_OFS_CMD       4'h4
`define MRF_OFS_STAT      4'h8

// Control register fields
`define MRF_CTRL_ASCII    0
`define MRF_CTRL_ZERO     1
`define MRF_CTRL_AVG      2
`define MRF_CTRL_AUTOSR   3
`define MRF_CTRL_STREAM   4
`define MRF_CTRL_HALFDUP  5
`define MRF_RST_ZERO      1'b0
`define MRF_RST_AVG       1'b0
`define MRF_RST_AUTOSR    1'b1
`define MRF_RST_STREAM    1'b1
`define MRF_RST_HALFDUP   1'b0

// Command register fields (write only, self clearing)
`define MRF_CMD_ASCII     0
`define MRF_CMD_BINARY    1
`define MRF_CMD_SINGLE    2

// Status register fields
`define MRF_STAT_BUSY     0
`define MRF_STAT_TXBUSY   1
`define MRF_STAT_SINGLE   2
`define MRF_STAT_CNT_LO   8

// ====================================================================
// Frame bytes
`define MRF_CR            8'h0D
`define MRF_SPACE         8'h20
`define MRF_MINUS         8'h2D
`define MRF_COMMA         8'h2C
`define MRF_ESC           8'h1B
`define MRF_DIGIT0        4'h3
`define MRF_VAL_PLAIN     8'h4F
`define MRF_VAL_ZERO      8'h50
`define MRF_VAL_SR        8'h53
`define MRF_VAL_SR_AVG    8'h56
`define MRF_VAL_SR_ZERO   8'h54
`define MRF_VAL_SR_BOTH   8'h57
`define MRF_BIN_LAST      5'h08
`define MRF_ASCII_LAST    5'h1B
`define MRF_FIELD_LAST    4'h8
`define MRF_AXIS_LAST     2'h2

// Output range, 1 gauss is 15000 counts
`define MRF_POS_LIMIT     16'h7530
`define MRF_NEG_LIMIT     16'h8AD0

// ====================================================================
// Timing
`define MRF_CLK_HZ        100000000
`define MRF_BAUD_BPS      19200
`define MRF_BAUD_DIV      (`MRF_CLK_HZ / `MRF_BAUD_BPS)
`define MRF_UART_BITS     4'hA
`define MRF_DEC_LAST      4'hE

`endif

// File: mrf_bin2dec.v
// Sequential binary to decimal converter for axis magnitudes up to 30000.
// Assumes start is a one-cycle pulse given only while the converter is idle.
`timescale 1ns/1ps
`include "mrf_regs.vh"

module mrf_bin2dec (
	input  wire        clk,
	input  wire        rstn,
	input  wire        start,
	input  wire [14:0] mag,
	output reg         done,
	output reg  [19:0] digits
);

	reg  [14:0] shiftIn;
	reg  [3:0]  cnt;
	reg         run;
	wire [19:0] adj;

	// ====================================================================
	// Add three to every digit of five or more before each shift
	genvar g;
	generate
		for (g = 0; g < 5; g = g + 1) begin : gAdj
			assign adj[4*g+3:4*g] = (digits[4*g+3:4*g] >= 4'h5) ?
				digits[4*g+3:4*g] + 4'h3 : digits[4*g+3:4*g];
		end
	endgenerate

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			shiftIn <= 15'h0000;
			digits  <= 20'h0_0000;
			cnt     <= 4'h0;
			run     <= 1'b0;
			done    <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				shiftIn <= mag;
				digits  <= 20'h0_0000;
				cnt     <= 4'h0;
				run     <= 1'b1;
			end else if (run) begin
				digits  <= {adj[18:0], shiftIn[14]};
				shiftIn <= {shiftIn[13:0], 1'b0};
				cnt     <= cnt + 4'h1;
				if (cnt == `MRF_DEC_LAST) begin
					run  <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end

endmodule // mrf_bin2dec

// File: mrf_uart_tx.v
// Byte transmitter, 8 data bits, no parity, one stop bit, LSB first.
// Assumes baudTick is a one-cycle pulse at the bit rate and start comes only while idle.
`timescale 1ns/1ps
`include "mrf_regs.vh"

module mrf_uart_tx (
	input  wire       clk,
	input  wire       rstn,
	input  wire       baudTick,
	input  wire       start,
	input  wire [7:0] data,
	output reg        busy,
	output reg        txd
);

	reg [9:0] shiftOut;
	reg [3:0] bitCnt;

	// Bits leave on baud ticks only, so the start bit may begin up to one bit time late
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			shiftOut <= 10'h3FF;
			bitCnt   <= 4'h0;
			busy     <= 1'b0;
			txd      <= 1'b1;
		end else if (start && !busy) begin
			shiftOut <= {1'b1, data, 1'b0};
			bitCnt   <= 4'h0;
			busy     <= 1'b1;
		end else if (busy && baudTick) begin
			if (bitCnt == `MRF_UART_BITS) begin
				busy <= 1'b0;
			end else begin
				txd      <= shiftOut[0];
				shiftOut <= {1'b1, shiftOut[9:1]};
				bitCnt   <= bitCnt + 4'h1;
			end
		end
	end

endmodule // mrf_uart_tx

// File: mrf_framer.v
// Magnetometer reading framer: takes one three-axis reading and sends it as a binary
// or ASCII decimal frame on a serial line, with a register port for control.
// Assumes readings arrive already scaled to counts, and received bytes arrive decoded
// by a receiver outside this block, all synchronous to clk.
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "mrf_regs.vh"

// Behaviour
// - Each axis is held as a signed 16-bit count before framing.
// - Select-ASCII and select-binary commands switch the output framing.
// - Binary frame: x hi, x lo, y, z, validity, checksum, CR; nine bytes.
// - Checksum is ones complement of six axis bytes plus validity.
// - Every frame ends with carriage return 0D.
// - One gauss is 15000 counts; output clamped to plus or minus 30000.
// - Auto set/reset off: validity 4F, or 50 with zero-reading on.
// - Auto set/reset on: validity 53, 56, 54 or 57 by zero and averaging.
// - ASCII frame: per axis sign, two digits, separator, three digits, two spaces; CR.
// - Sign character is minus for negative, space otherwise.
// - Separator is comma when leading two digits not both zero, else space.
// - Digits are ASCII decimal; leading zeros in first three places become spaces.
// - Full-duplex line: sending and receiving overlap freely.
// - Half-duplex line: only one party drives at a time.
// - Half-duplex: escape stops continuous output only when not transmitting.
module mrf_framer #(
	parameter BAUD_DIV = `MRF_BAUD_DIV
) (
	input  wire        clk,
	input  wire        rstn,
	input  wire [3:0]  regAddr,
	input  wire [31:0] regWdata,
	input  wire        regWr,
	input  wire        regRd,
	output reg  [31:0] regRdata,
	input  wire        sampleValid,
	input  wire [15:0] sampleX,
	input  wire [15:0] sampleY,
	input  wire [15:0] sampleZ,
	output wire        sampleReady,
	input  wire        rxValid,
	input  wire [7:0]  rxData,
	output wire        txd,
	output wire        txOe
);

	localparam ST_IDLE  = 3'd0;
	localparam ST_CONV  = 3'd1;
	localparam ST_CWAIT = 3'd2;
	localparam ST_SEND  = 3'd3;
	localparam ST_SWAIT = 3'd4;

	// ====================================================================
	// Control state
	reg        asciiMode;
	reg        zeroOn;
	reg        avgOn;
	reg        autoSr;
	reg        streamOn;
	reg        halfDup;
	reg        singlePend;
	reg  [7:0] frameCount;

	reg  [2:0] state;
	reg        frameAscii;
	reg  [4:0] byteIdx;
	reg  [3:0] posIdx;
	reg  [1:0] axisIdx;
	reg [15:0] axX;
	reg [15:0] axY;
	reg [15:0] axZ;
	reg  [7:0] validity;
	reg  [7:0] checksum;
	reg [19:0] digs [0:2];
	reg [15:0] baudCnt;
	reg        baudTick;

	wire        txBusy;
	wire        convDone;
	wire [19:0] convDigits;
	wire        ctrlWr = regWr && (regAddr == `MRF_OFS_CTRL);
	wire        cmdWr  = regWr && (regAddr == `MRF_OFS_CMD);
	wire        accept = sampleValid && sampleReady;
	wire        escHit = rxValid && (rxData == `MRF_ESC) && !(halfDup && txBusy);
	wire        txStart = (state == ST_SEND) && !txBusy;
	wire        lastByte = frameAscii ? (byteIdx == `MRF_ASCII_LAST) : (byteIdx == `MRF_BIN_LAST);

	assign sampleReady = (state == ST_IDLE) && (streamOn || singlePend);
	assign txOe        = halfDup ? txBusy : 1'b1;

	// ====================================================================
	// Reading preparation
	function [15:0] clampAxis;
		input [15:0] v;
		begin
			if (!v[15] && (v > `MRF_POS_LIMIT))
				clampAxis = `MRF_POS_LIMIT;
			else if (v[15] && (v < `MRF_NEG_LIMIT))
				clampAxis = `MRF_NEG_LIMIT;
			else
				clampAxis = v;
		end
	endfunction

	wire [15:0] inX = clampAxis(sampleX);
	wire [15:0] inY = clampAxis(sampleY);
	wire [15:0] inZ = clampAxis(sampleZ);

	reg [7:0] nextValidity;
	always @* begin
		if (!autoSr) begin
			nextValidity = zeroOn ? `MRF_VAL_ZERO : `MRF_VAL_PLAIN;
		end else begin
			case ({zeroOn, avgOn})
				2'b00:   nextValidity = `MRF_VAL_SR;
				2'b01:   nextValidity = `MRF_VAL_SR_AVG;
				2'b10:   nextValidity = `MRF_VAL_SR_ZERO;
				default: nextValidity = `MRF_VAL_SR_BOTH;
			endcase
		end
	end

	// Carries drop out because every term and the sum are eight bits wide
	wire [7:0] byteSum = inX[15:8] + inX[7:0] + inY[15:8] + inY[7:0] +
		inZ[15:8] + inZ[7:0] + nextValidity;
	wire [7:0] nextChecksum = ~byteSum;

	// ====================================================================
	// Decimal conversion of the selected axis magnitude
	reg [15:0] curAxis;
	always @* begin
		case (axisIdx)
			2'd0:    curAxis = axX;
			2'd1:    curAxis = axY;
			default: curAxis = axZ;
		endcase
	end

	wire [15:0] negAxis = 16'h0000 - curAxis;
	wire [14:0] curMag  = curAxis[15] ? negAxis[14:0] : curAxis[14:0];

	mrf_bin2dec uDec (
		.clk    (clk),
		.rstn   (rstn),
		.start  (state == ST_CONV),
		.mag    (curMag),
		.done   (convDone),
		.digits (convDigits)
	);

	// ====================================================================
	// Byte selection
	wire [19:0] d     = digs[axisIdx];
	wire        lead1 = (d[19:16] == 4'h0);
	wire        lead2 = lead1 && (d[15:12] == 4'h0);
	wire        lead3 = lead2 && (d[11:8] == 4'h0);

	reg [15:0] binAxis;
	always @* begin
		case (byteIdx[2:1])
			2'd0:    binAxis = axX;
			2'd1:    binAxis = axY;
			default: binAxis = axZ;
		endcase
	end

	reg [7:0] curByte;
	always @* begin
		curByte = `MRF_CR;
		if (!frameAscii) begin
			if (byteIdx < 5'h06)
				curByte = byteIdx[0] ? binAxis[7:0] : binAxis[15:8];
			else if (byteIdx == 5'h06)
				curByte = validity;
			else if (byteIdx == 5'h07)
				curByte = checksum;
			else
				curByte = `MRF_CR;
		end else if (byteIdx == `MRF_ASCII_LAST) begin
			curByte = `MRF_CR;
		end else begin
			case (posIdx)
				4'h0:    curByte = curAxis[15] ? `MRF_MINUS : `MRF_SPACE;
				4'h1:    curByte = lead1 ? `MRF_SPACE : {`MRF_DIGIT0, d[19:16]};
				4'h2:    curByte = lead2 ? `MRF_SPACE : {`MRF_DIGIT0, d[15:12]};
				4'h3:    curByte = lead2 ? `MRF_SPACE : `MRF_COMMA;
				4'h4:    curByte = lead3 ? `MRF_SPACE : {`MRF_DIGIT0, d[11:8]};
				4'h5:    curByte = {`MRF_DIGIT0, d[7:4]};
				4'h6:    curByte = {`MRF_DIGIT0, d[3:0]};
				default: curByte = `MRF_SPACE;
			endcase
		end
	end

	// ====================================================================
	// Serial output
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			baudCnt  <= 16'h0000;
			baudTick <= 1'b0;
		end else if (baudCnt == BAUD_DIV[15:0] - 16'h0001) begin
			baudCnt  <= 16'h0000;
			baudTick <= 1'b1;
		end else begin
			baudCnt  <= baudCnt + 16'h0001;
			baudTick <= 1'b0;
		end
	end

	mrf_uart_tx uTx (
		.clk      (clk),
		.rstn     (rstn),
		.baudTick (baudTick),
		.start    (txStart),
		.data     (curByte),
		.busy     (txBusy),
		.txd      (txd)
	);

	// ====================================================================
	// Control registers
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			asciiMode  <= 1'b0;
			zeroOn     <= `MRF_RST_ZERO;
			avgOn      <= `MRF_RST_AVG;
			autoSr     <= `MRF_RST_AUTOSR;
			streamOn   <= `MRF_RST_STREAM;
			halfDup    <= `MRF_RST_HALFDUP;
			singlePend <= 1'b0;
		end else begin
			if (cmdWr && regWdata[`MRF_CMD_ASCII])
				asciiMode <= 1'b1;
			else if (cmdWr && regWdata[`MRF_CMD_BINARY])
				asciiMode <= 1'b0;
			if (ctrlWr) begin
				zeroOn  <= regWdata[`MRF_CTRL_ZERO];
				avgOn   <= regWdata[`MRF_CTRL_AVG];
				autoSr  <= regWdata[`MRF_CTRL_AUTOSR];
				halfDup <= regWdata[`MRF_CTRL_HALFDUP];
			end
			// A software write in the same cycle as an escape is the later intent
			if (ctrlWr)
				streamOn <= regWdata[`MRF_CTRL_STREAM];
			else if (escHit)
				streamOn <= 1'b0;
			if (cmdWr && regWdata[`MRF_CMD_SINGLE])
				singlePend <= 1'b1;
			else if (accept || escHit)
				singlePend <= 1'b0;
		end
	end

	// ====================================================================
	// Frame sequencer
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state      <= ST_IDLE;
			frameAscii <= 1'b0;
			byteIdx    <= 5'h00;
			posIdx     <= 4'h0;
			axisIdx    <= 2'h0;
			axX        <= 16'h0000;
			axY        <= 16'h0000;
			axZ        <= 16'h0000;
			validity   <= 8'h00;
			checksum   <= 8'h00;
			frameCount <= 8'h00;
			digs[0]    <= 20'h0_0000;
			digs[1]    <= 20'h0_0000;
			digs[2]    <= 20'h0_0000;
		end else begin
			case (state)
				ST_IDLE: begin
					if (accept) begin
						// Mode is sampled per frame so a command never splits a frame
						frameAscii <= asciiMode;
						axX        <= inX;
						axY        <= inY;
						axZ        <= inZ;
						validity   <= nextValidity;
						checksum   <= nextChecksum;
						byteIdx    <= 5'h00;
						posIdx     <= 4'h0;
						axisIdx    <= 2'h0;
						state      <= asciiMode ? ST_CONV : ST_SEND;
					end
				end
				ST_CONV: begin
					state <= ST_CWAIT;
				end
				ST_CWAIT: begin
					if (convDone) begin
						digs[axisIdx] <= convDigits;
						if (axisIdx == `MRF_AXIS_LAST) begin
							axisIdx <= 2'h0;
							state   <= ST_SEND;
						end else begin
							axisIdx <= axisIdx + 2'h1;
							state   <= ST_CONV;
						end
					end
				end
				ST_SEND: begin
					if (!txBusy)
						state <= ST_SWAIT;
				end
				ST_SWAIT: begin
					if (!txBusy) begin
						if (lastByte) begin
							frameCount <= frameCount + 8'h01;
							state      <= ST_IDLE;
						end else begin
							byteIdx <= byteIdx + 5'h01;
							if (posIdx == `MRF_FIELD_LAST) begin
								posIdx  <= 4'h0;
								axisIdx <= axisIdx + 2'h1;
							end else begin
								posIdx <= posIdx + 4'h1;
							end
							state <= ST_SEND;
						end
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ====================================================================
	// Register read port, data valid one cycle after the strobe
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			regRdata <= 32'h0000_0000;
		end else if (regRd) begin
			regRdata <= 32'h0000_0000;
			case (regAddr)
				`MRF_OFS_CTRL: begin
					regRdata[`MRF_CTRL_ASCII]   <= asciiMode;
					regRdata[`MRF_CTRL_ZERO]    <= zeroOn;
					regRdata[`MRF_CTRL_AVG]     <= avgOn;
					regRdata[`MRF_CTRL_AUTOSR]  <= autoSr;
					regRdata[`MRF_CTRL_STREAM]  <= streamOn;
					regRdata[`MRF_CTRL_HALFDUP] <= halfDup;
				end
				`MRF_OFS_STAT: begin
					regRdata[`MRF_STAT_BUSY]   <= (state != ST_IDLE);
					regRdata[`MRF_STAT_TXBUSY] <= txBusy;
					regRdata[`MRF_STAT_SINGLE] <= singlePend;
					regRdata[`MRF_STAT_CNT_LO+7:`MRF_STAT_CNT_LO] <= frameCount;
				end
				default: begin
					regRdata <= 32'h0000_0000;
				end
			endcase
		end else begin
			regRdata <= 32'h0000_0000;
		end
	end

endmodule // mrf_framer

// File: mrf_framer_sva.sv
// Port checker for the reading framer.
// Assumes one clock domain; attached to every framer instance by the bind below.
`timescale 1ns/1ps
module mrf_framer_sva #(
	parameter BAUD_DIV = 8
) (
	input wire        clk,
	input wire        rstn,
	input wire [3:0]  regAddr,
	input wire        regRd,
	input wire [31:0] regRdata,
	input wire        sampleValid,
	input wire        sampleReady,
	input wire        txd,
	input wire        txOe
);
	// Conversion of an ASCII reading adds some fifty cycles before the first start bit
	localparam int startMax = 2 * BAUD_DIV + 80;
	localparam int lowMax   = 9 * BAUD_DIV + 2;
	int lowCnt;
	int startCnt;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// ========
	// Helper logic and sequences
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			lowCnt <= 0;
		else
			lowCnt <= txd ? 0 : lowCnt + 1;
	end
	// A counter, not a delay range, so a full-rate divider stays within tool limits
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			startCnt <= 0;
		else if (sampleValid && sampleReady)
			startCnt <= 1;
		else if (startCnt != 0)
			startCnt <= txd ? startCnt + 1 : 0;
	end
	sequence accept;
		sampleValid && sampleReady;
	endsequence
	// ========
	// Assertions
	rdata_zero_a:
	assert property ((!regRd || (regAddr != 4'h0 && regAddr != 4'h8)) |=> regRdata == 32'h0000_0000)
		else $error("read data not zero outside a register read");
	reserved_bits_a:
	assert property (regRd && regAddr == 4'h0 |=> regRdata[31:6] == 26'h0)
		else $error("reserved control bits read nonzero");
	start_bound_a:
	assert property (startCnt <= startMax) else $error("no start bit after accepted reading");
	one_frame_a:
	assert property (accept |=> !sampleReady [*8]) else $error("reading taken while frame runs");
	line_busy_a:
	assert property (!txd |-> !sampleReady) else $error("ready while line is sending");
	low_run_a:
	assert property (lowCnt <= lowMax) else $error("line held low beyond one byte");
	oe_drive_a:
	assert property (!txd |-> txOe) else $error("line driven low without output enable");
	oe_release_a:
	assert property ($fell(txOe) |-> txd && $past(txd)) else $error("line released in mid byte");
endmodule // mrf_framer_sva

bind mrf_framer mrf_framer_sva #(.BAUD_DIV(BAUD_DIV)) mrf_framer_sva_i (
	.clk(clk), .rstn(rstn), .regAddr(regAddr), .regRd(regRd), .regRdata(regRdata),
	.sampleValid(sampleValid), .sampleReady(sampleReady), .txd(txd), .txOe(txOe)
);

// File: mrf_host_model.sv
// Host end of the serial link: decodes frame bytes and may answer with escape.
// Assumes 8N1 framing at BAUD_DIV clocks per bit, line idle high.
`timescale 1ns/1ps
module mrf_host_model #(
	parameter BAUD_DIV = 8
) (
	input  wire       clk,
	input  wire       rstn,
	input  wire       txd,
	input  wire       escAfterCr,
	output reg        byteValid,
	output reg  [7:0] byteData,
	output reg        rxValid,
	output reg  [7:0] rxData
);
	reg [7:0] shift;
	integer   i;
	// ========
	// Receiver, sampling mid bit
	initial begin
		byteValid = 1'b0;
		byteData  = 8'h00;
		rxValid   = 1'b0;
		rxData    = 8'hE4;
		forever begin
			@(posedge clk);
			if (rstn && !txd) begin
				repeat (BAUD_DIV / 2) @(posedge clk);
				for (i = 0; i < 8; i = i + 1) begin
					repeat (BAUD_DIV) @(posedge clk);
					shift[i] = txd;
				end
				repeat (BAUD_DIV) @(posedge clk);
				byteData  <= shift;
				// A bad stop bit drops the byte
				byteValid <= txd;
				@(posedge clk);
				byteValid <= 1'b0;
				// Ten bit times stand for the escape's own time on the wire
				if (escAfterCr && shift == 8'h0D) begin
					repeat (10 * BAUD_DIV) @(posedge clk);
					rxValid <= 1'b1;
					rxData  <= 8'h1B;
					@(posedge clk);
					rxValid <= 1'b0;
					rxData  <= 8'hE4;
				end
			end
		end
	end
endmodule // mrf_host_model

// File: testbench.sv
// Self-checking bench for the reading framer: registers, binary and ASCII frames, escape.
// Assumes the host model and the checker are compiled before it.
`timescale 1ns/1ps
module testbench;
	localparam BD = 8;
	reg         clk = 1'b0;
	reg         rstn = 1'b0;
	reg  [3:0]  regAddr = 4'h0;
	reg  [31:0] regWdata = 32'h0000_0000;
	reg         regWr = 1'b0;
	reg         regRd = 1'b0;
	reg         sampleValid = 1'b0;
	reg  [15:0] sampleX = 16'h0000;
	reg  [15:0] sampleY = 16'h0000;
	reg  [15:0] sampleZ = 16'h0000;
	reg         escNow = 1'b0;
	reg         escAfterCr = 1'b0;
	wire [31:0] regRdata;
	wire        sampleReady, txd, txOe, hostRxValid, byteValid;
	wire [7:0]  hostRxData, byteData;
	wire        rxValid = hostRxValid | escNow;
	wire [7:0]  rxData = escNow ? 8'h1B : hostRxData;
	integer     errorCnt = 0;
	integer     testsRun = 0;
	reg  [7:0]  rxq[$];
	reg  [15:0] vals [0:7] = '{16'h7530, 16'h8AD0, 16'h3A98, 16'hC374, 16'h1D4C, 16'hE2B4, 16'h7FFF, 16'h8000};

	always #5 clk = ~clk;
	mrf_framer #(.BAUD_DIV(BD)) mrf_framer_i (
		.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .sampleValid(sampleValid), .sampleX(sampleX), .sampleY(sampleY),
		.sampleZ(sampleZ), .sampleReady(sampleReady), .rxValid(rxValid), .rxData(rxData),
		.txd(txd), .txOe(txOe)
	);
	mrf_host_model #(.BAUD_DIV(BD)) mrf_host_model_i (
		.clk(clk), .rstn(rstn), .txd(txd), .escAfterCr(escAfterCr), .byteValid(byteValid),
		.byteData(byteData), .rxValid(hostRxValid), .rxData(hostRxData)
	);
	always @(posedge clk) begin
		if (byteValid)
			rxq.push_back(byteData);
	end

	// ========
	// Helpers
	function [15:0] clampV(input [15:0] v);
		clampV = ($signed(v) > 30000) ? 16'h7530 : ($signed(v) < -30000) ? 16'h8AD0 : v;
	endfunction
	function [7:0] asc(input [15:0] raw, input integer p);
		integer m;
		begin
			m = $signed(clampV(raw));
			if (m < 0)
				m = -m;
			case (p)
				0: asc = raw[15] ? 8'h2D : 8'h20;
				1: asc = (m < 10000) ? 8'h20 : 8'(48 + m / 10000);
				2: asc = (m < 1000) ? 8'h20 : 8'(48 + (m / 1000) % 10);
				3: asc = (m < 1000) ? 8'h20 : 8'h2C;
				4: asc = (m < 100) ? 8'h20 : 8'(48 + (m / 100) % 10);
				5: asc = 8'(48 + (m / 10) % 10);
				6: asc = 8'(48 + m % 10);
				default: asc = 8'h20;
			endcase
		end
	endfunction
	task check(input string name, input [31:0] seen, input [31:0] exp);
		begin
			testsRun = testsRun + 1;
			if (seen !== exp) begin
				errorCnt = errorCnt + 1;
				$display("[ERR] %s expected %h seen %h", name, exp, seen);
			end
		end
	endtask
	task regWrite(input [3:0] a, input [31:0] d);
		begin
			@(posedge clk);
			regAddr  <= a;
			regWdata <= d;
			regWr    <= 1'b1;
			@(posedge clk);
			regWr    <= 1'b0;
		end
	endtask
	task regRead(input [3:0] a, output [31:0] d);
		begin
			@(posedge clk);
			regAddr <= a;
			regRd   <= 1'b1;
			@(posedge clk);
			regRd   <= 1'b0;
			#1 d = regRdata;
		end
	endtask
	task sendFrame(input [15:0] x, input [15:0] y, input [15:0] z, input integer n);
		integer k;
		begin
			rxq.delete();
			@(posedge clk);
			sampleX     <= x;
			sampleY     <= y;
			sampleZ     <= z;
			sampleValid <= 1'b1;
			k = 0;
			@(negedge clk);
			while (sampleReady !== 1'b1 && k < 100) begin
				@(negedge clk);
				k = k + 1;
			end
			@(posedge clk);
			sampleValid <= 1'b0;
			while (rxq.size() < n && k < 40 * n * BD) begin
				@(posedge clk);
				k = k + 1;
			end
			repeat (3 * BD) @(posedge clk);
			@(negedge clk);
			check("frame length", rxq.size(), n);
		end
	endtask
	task checkBin(input [15:0] x, input [15:0] y, input [15:0] z, input [7:0] vb);
		reg [55:0] e;
		reg [7:0]  sum;
		integer    i;
		begin
			e = {clampV(x), clampV(y), clampV(z), vb};
			sum = 8'h00;
			for (i = 0; i < 7; i = i + 1)
				sum = sum + e[55 - 8 * i -: 8];
			sum = ~sum;
			for (i = 0; i < 6; i = i + 1)
				check("axis byte", rxq[i], e[55 - 8 * i -: 8]);
			check("validity", rxq[6], vb);
			check("checksum", rxq[7], sum);
			check("binary end", rxq[8], 8'h0D);
		end
	endtask
	task checkAscii(input [15:0] x, input [15:0] y, input [15:0] z);
		reg [47:0] v;
		integer    i;
		begin
			v = {x, y, z};
			sendFrame(x, y, z, 28);
			for (i = 0; i < 27; i = i + 1)
				check("ascii byte", rxq[i], asc(v[47 - 16 * (i / 9) -: 16], i % 9));
			check("ascii end", rxq[27], 8'h0D);
		end
	endtask
	task escMidFrame(input [15:0] x);
		fork
			sendFrame(x, 16'h0000, 16'h8000, 9);
			begin
				wait (rxq.size() == 3);
				// Land well inside the next byte, not on the edge where the line goes idle
				repeat (2 * BD) @(posedge clk);
				escNow <= 1'b1;
				@(posedge clk);
				escNow <= 1'b0;
			end
		join
	endtask

	// ========
	// Scenarios
	task tRegs;
		reg [31:0] d;
		begin
			regRead(4'h0, d);
			check("control reset", d, 32'h0000_0018);
			regRead(4'h4, d);
			check("command read", d, 32'h0000_0000);
			regRead(4'hC, d);
			check("unmapped read", d, 32'h0000_0000);
			$display("register test done");
		end
	endtask
	task tBinary;
		integer   c;
		reg [7:0] vb;
		begin
			for (c = 0; c < 8; c = c + 1) begin
				regWrite(4'h0, 32'h0000_0010 | (c << 1));
				vb = c[2] ? (c[0] ? (c[1] ? 8'h57 : 8'h54) : (c[1] ? 8'h56 : 8'h53)) : (c[0] ? 8'h50 : 8'h4F);
				sendFrame(vals[c], vals[(c + 3) % 8], vals[(c + 6) % 8], 9);
				checkBin(vals[c], vals[(c + 3) % 8], vals[(c + 6) % 8], vb);
			end
			$display("binary test done");
		end
	endtask
	task tAscii;
		reg [31:0] d;
		begin
			regWrite(4'h4, 32'h0000_0001);
			regRead(4'h0, d);
			check("ascii selected", d[0], 1'b1);
			checkAscii(16'hE2B4, 16'h002D, 16'h3039);
			checkAscii(16'h7FFF, 16'h0000, 16'hFC18);
			regWrite(4'h4, 32'h0000_0002);
			regRead(4'h0, d);
			check("binary selected", d[0], 1'b0);
			sendFrame(16'h0001, 16'hFFFF, 16'h0100, 9);
			checkBin(16'h0001, 16'hFFFF, 16'h0100, 8'h57);
			$display("ascii test done");
		end
	endtask
	task tEscape;
		begin
			regWrite(4'h0, 32'h0000_0038);
			@(negedge clk);
			check("enable idle shared line", txOe, 1'b0);
			escMidFrame(16'h1234);
			check("ready after busy escape", sampleReady, 1'b1);
			escAfterCr <= 1'b1;
			sendFrame(16'h0010, 16'h0020, 16'h0030, 9);
			repeat (12 * BD) @(posedge clk);
			@(negedge clk);
			check("stopped after escape", sampleReady, 1'b0);
			escAfterCr <= 1'b0;
			regWrite(4'h0, 32'h0000_0018);
			@(negedge clk);
			check("enable full duplex", txOe, 1'b1);
			escMidFrame(16'h4321);
			check("stopped by overlapped escape", sampleReady, 1'b0);
			$display("escape test done");
		end
	endtask
	task tSingle;
		reg [31:0] d;
		begin
			regWrite(4'h4, 32'h0000_0004);
			regRead(4'h8, d);
			check("single pending", d, 32'h0000_0E04);
			sendFrame(16'h0BB8, 16'hF448, 16'h0000, 9);
			checkBin(16'h0BB8, 16'hF448, 16'h0000, 8'h53);
			regRead(4'h8, d);
			check("single consumed", d, 32'h0000_0F00);
			check("single stops", sampleReady, 1'b0);
			$display("single test done");
		end
	endtask
	task testDone;
		begin
			$display("comparisons %0d mismatches %0d", testsRun, errorCnt);
			if (errorCnt == 0 && testsRun > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask

	// ========
	// Sequence and watchdog
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		tRegs;
		tBinary;
		tAscii;
		tEscape;
		tSingle;
		testDone;
	end
	initial begin
		// The tests need about 20k cycles; 100k cycles means a hang
		#1_000_000;
		errorCnt = errorCnt + 1;
		testDone;
	end
endmodule // testbench
